// ===== bench/bit_lock_asserts.sv
// Checker for the bit write protection lock, bound to its top module.
// Assumes one pclk domain and the same WINDOW_CYCLES as the bound instance.
`timescale 1ns/1ps
`default_nettype none

module bit_lock_asserts #(
  parameter int unsigned WINDOW_CYCLES = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic powerdown_exit,
  input wire logic [3:0] feedback_divider,
  input wire logic output_divider,
  input wire logic watchdog_enable_bit,
  input wire logic powerdown_enable,
  input wire logic slowdown_enable,
  input wire logic [3:0] clock_reload,
  input wire logic lock_state
);
  // ****************
  // Model of the lock mode and the open window
  // ****************
  logic wr, key_wr;
  logic [1:0] mode_q;
  logic [6:0] cnt_q;

  // Accepted writes, and those to the key register.
  assign wr = psel && penable && pwrite && pstrb[0] && ce;
  assign key_wr = wr && paddr == bit_lock_pkg::ADDR_BIT_LOCK_KEY;

  // The mode changes only with the set-mode key.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode_q <= 2'h3;
    else if (key_wr && pwdata[7:3] == bit_lock_pkg::KEY_SET_MODE)
      mode_q <= pwdata[1:0];
  end

  // Cycles left in the window; keys act only in protected mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_q <= 7'h00;
    else if (!ce)
      cnt_q <= cnt_q;
    else if (key_wr && mode_q == 2'h3 && pwdata[7:3] == bit_lock_pkg::KEY_OPEN)
      cnt_q <= 7'(WINDOW_CYCLES);
    else if (key_wr && mode_q == 2'h3 && pwdata[7:3] == bit_lock_pkg::KEY_CLOSE)
      cnt_q <= 7'h00;
    else if (cnt_q != 7'h00)
      cnt_q <= cnt_q - 7'h01;
  end

  // ****************
  // Properties
  // ****************
  default clocking ck @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  reset_locked_a: assert property ($rose(presetn) |-> lock_state)
    else $error("lock not closed after reset");
  window_open_a: assert property (cnt_q != 7'h00 |-> !lock_state)
    else $error("lock closed inside the window");
  window_shut_a: assert property (
    cnt_q == 7'h00 && mode_q == 2'h3 |-> lock_state)
    else $error("lock open outside the window");
  mode_off_a: assert property (mode_q != 2'h3 |-> !lock_state)
    else $error("lock closed with protection off");
  locked_hold_a: assert property (lock_state |=>
    $stable({feedback_divider, output_divider, watchdog_enable_bit, slowdown_enable}))
    else $error("protected bit changed while locked");
  pd_hold_a: assert property (
    lock_state && !powerdown_exit |=> $stable(powerdown_enable))
    else $error("power-down enable changed while locked");
  open_write_a: assert property (
    wr && paddr == bit_lock_pkg::ADDR_CLOCK_MULTIPLIER_CONTROL && !lock_state
    |=> feedback_divider == $past(pwdata[7:4]))
    else $error("feedback divider missed an open write");
  free_bits_a: assert property (
    wr && paddr == bit_lock_pkg::ADDR_CLOCK_CONTROL |=> clock_reload == $past(pwdata[3:0]))
    else $error("clock reload missed a write");

  expiry_c: cover property (cnt_q == 7'h01 ##1 lock_state);
  mode_off_c: cover property (mode_q == 2'h0);
  reopen_c: cover property (key_wr && cnt_q != 7'h00 && pwdata[7:3] == bit_lock_pkg::KEY_OPEN);
endmodule

bind bit_lock bit_lock_asserts #(.WINDOW_CYCLES(WINDOW_CYCLES)) chk_i (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .powerdown_exit,
  .feedback_divider, .output_divider, .watchdog_enable_bit, .powerdown_enable,
  .slowdown_enable, .clock_reload, .lock_state);

`default_nettype wire

// ===== bench/bit_lock_tb_top.sv
// Self-checking bench for the bit write protection lock over APB.
// Assumes the package and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module bit_lock_tb_top;
  // ****************
  // Bench state and the design
  // ****************
  localparam int unsigned WIN = 16;
  localparam logic [11:0] KA = bit_lock_pkg::ADDR_BIT_LOCK_KEY;
  localparam logic [11:0] AD [4] = '{bit_lock_pkg::ADDR_POWER_MODE_CONTROL_0,
    bit_lock_pkg::ADDR_CLOCK_MULTIPLIER_CONTROL, bit_lock_pkg::ADDR_WATCHDOG_CONTROL,
    bit_lock_pkg::ADDR_CLOCK_CONTROL};
  localparam logic [7:0] RV [4] = '{8'h00, 8'h90, 8'h00, 8'h10};
  localparam logic [7:0] RW [4] = '{8'h1F, 8'hFC, 8'h01, 8'hDF};
  localparam logic [7:0] PR [4] = '{8'h0C, 8'hF0, 8'h01, 8'h40};
  logic [32:0] exp_q [$];
  logic [7:0] sh [4];
  logic [31:0] rs = 32'h45B0EC6F;
  int err_total = 0, checked = 0;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [3:0] feedback_divider;
  logic output_divider, watchdog_enable_bit, powerdown_enable, slowdown_enable, lock_state;

  bit_lock #(.WINDOW_CYCLES(WIN)) uut (
    .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pll_locked_async(1'b0), .watchdog_reset_event(1'b0),
    .wakeup_event(1'b0), .powerdown_exit(1'b0), .feedback_divider, .output_divider,
    .watchdog_enable_bit, .powerdown_enable, .slowdown_enable, .wakeup_source(),
    .wakeup_select(), .vco_bypass(), .osc_disconnect(), .restart_lock_pulse(), .vco_select(),
    .fast_clock_cfg(), .clock_reload(), .lock_state);

  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;

  // ****************
  // Helpers
  // ****************
  // Xorshift source of write data and strobes.
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= {3'h7, s};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic s);
    apb(1'b1, a, d, s);
  endtask

  // A read notes its expected data and error flag first.
  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic e);
    exp_q.push_back({e, v});
    apb(1'b0, a, 8'h00, 1'b1);
  endtask

  // Opens the window and checks the cycle at which it closes.
  task automatic window_check();
    wr(KA, 8'h98, 1'b1);
    #1;
    chk("lock_state opened", 32'h0, lock_state);
    repeat (WIN - 1) @(posedge pclk);
    #1;
    chk("lock_state last open cycle", 32'h0, lock_state);
    @(posedge pclk);
    #1;
    chk("lock_state expired", 32'h1, lock_state);
  endtask

  // Takes the oldest note off the queue at each completed read.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[FAIL] read note expected one seen none %h", prdata);
      end else begin
        chk("prdata", exp_q[0][31:0], prdata);
        chk("pslverr", 32'(exp_q[0][32]), pslverr);
        void'(exp_q.pop_front());
      end
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [7:0] d, mk;
    logic [1:0] m;
    logic s;
    sh = RV;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("lock_state after reset", 32'h1, lock_state);
    for (int r = 0; r < 4; r++)
      rd(AD[r], {24'h0, RV[r]}, 1'b0);
    rd(KA, 32'h07, 1'b0);
    $display("test reset_values done");
    // Random writes; window open on even passes, shut on odd ones.
    for (int k = 0; k < 4; k++) begin
      if (!k[0])
        wr(KA, 8'h98, 1'b1);
      for (int r = 0; r < 4; r++) begin
        d = 8'(rnd()) & RW[r];
        s = (rnd() & 32'h3) != 32'h0;
        mk = k[0] ? ~PR[r] : 8'hFF;
        if (s)
          sh[r] = (sh[r] & ~(RW[r] & mk)) | (d & mk);
        wr(AD[r], d, s);
      end
      #1;
      chk("feedback_divider", 32'(sh[1][7:4]), feedback_divider);
      chk("output_divider", 32'(sh[3][6]), output_divider);
      chk("watchdog_enable_bit", 32'(sh[2][0]), watchdog_enable_bit);
      chk("powerdown_enable", 32'(sh[0][2]), powerdown_enable);
      chk("slowdown_enable", 32'(sh[0][3]), slowdown_enable);
      for (int r = 0; r < 4; r++)
        rd(AD[r], {24'h0, sh[r]}, 1'b0);
      $display("test write_pass %0d done", k);
    end
    window_check();
    wr(KA, 8'h98, 1'b1);
    repeat (5) @(posedge pclk);
    window_check();
    $display("test window_timing done");
    wr(KA, 8'h98, 1'b1);
    rd(KA, 32'h03, 1'b0);
    wr(KA, 8'hA8, 1'b1);
    #1;
    chk("lock_state closed", 32'h1, lock_state);
    rd(KA, 32'h07, 1'b0);
    $display("test close_key done");
    // Every mode, a stray close key and a watchdog write.
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      wr(KA, {5'h18, 1'b1, m}, 1'b1);
      wr(KA, {5'h15, 1'b0, ~m}, 1'b1);
      rd(KA, {29'h0, m == 2'h3, m}, 1'b0);
      wr(AD[2], sh[2] ^ 8'h01, 1'b1);
      if (m != 2'h3)
        sh[2] = sh[2] ^ 8'h01;
      rd(AD[2], {24'h0, sh[2]}, 1'b0);
    end
    $display("test lock_modes done");
    rd(12'h000, 32'h0, 1'b1);
    $display("test unmapped done");
    repeat (3) @(posedge pclk);
    chk("pending read notes", 32'h0, exp_q.size());
    report_and_stop();
  end
endmodule

`default_nettype wire

// ===== common/bit_lock_pkg.sv
// Package with the register map, field layout, reset values, key codes and
// counts of the bit write protection lock.
// Assumes a 100 MHz pclk and an APB slave with 32-bit data, one word a register.
//
// Functional notes
// [R01] Block protected bit writes unless access opened.
// [R02] Mode 11: key 10011 opens protected access.
// [R03] Mode 11: key 10101 closes protected access.
// [R04] Open/close key writes leave mode unchanged.
// [R05] Mode updates only with key 11000.
// [R06] Open window closes itself after 32 cycles.
// [R07] Reopening restarts the full 32-cycle window.
// [R08] Protected: dividers, watchdog, power-down, slow-down enables.
// [R09] Key register resets to 07h, locked.
// [R10] Locked write keeps protected bits, updates others.
// [R11] Lock state flag reads 1 only while locked.

package bit_lock_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam int unsigned ADDR_WIDTH = 12;
  localparam logic [7:0] IDX_POWER_MODE_CONTROL_0 = 8'hB4;
  localparam logic [7:0] IDX_CLOCK_MULTIPLIER_CONTROL = 8'hB7;
  localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'hB9;
  localparam logic [7:0] IDX_CLOCK_CONTROL = 8'hBA;
  localparam logic [7:0] IDX_BIT_LOCK_KEY = 8'hBB;
  localparam logic [11:0] ADDR_POWER_MODE_CONTROL_0 = {2'h0, IDX_POWER_MODE_CONTROL_0, 2'h0};
  localparam logic [11:0] ADDR_CLOCK_MULTIPLIER_CONTROL =
    {2'h0, IDX_CLOCK_MULTIPLIER_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_WATCHDOG_CONTROL = {2'h0, IDX_WATCHDOG_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_CLOCK_CONTROL = {2'h0, IDX_CLOCK_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_BIT_LOCK_KEY = {2'h0, IDX_BIT_LOCK_KEY, 2'h0};

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_POWER_MODE_CONTROL_0 = 8'h00;
  localparam logic [7:0] RST_CLOCK_MULTIPLIER_CONTROL = 8'h90;
  localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_CONTROL = 8'h10;
  localparam logic [4:0] RST_KEY_FIELD = 5'h00;
  localparam logic RST_LOCK_STATE = 1'b1;
  localparam logic [1:0] RST_LOCK_MODE = 2'h3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned POS_WDT_RESET_FLAG = 6;
  localparam int unsigned POS_WAKEUP_FLAG = 5;
  localparam int unsigned POS_WAKEUP_SELECT = 4;
  localparam int unsigned POS_SLOWDOWN = 3;
  localparam int unsigned POS_POWERDOWN = 2;
  localparam int unsigned POS_WAKEUP_SOURCE_LO = 0;
  localparam int unsigned POS_FEEDBACK_DIV_LO = 4;
  localparam int unsigned POS_VCO_BYPASS = 3;
  localparam int unsigned POS_OSC_DISCONNECT = 2;
  localparam int unsigned POS_RESTART_LOCK = 1;
  localparam int unsigned POS_PLL_LOCKED = 0;
  localparam int unsigned POS_WATCHDOG_ENABLE = 0;
  localparam int unsigned POS_VCO_SELECT = 7;
  localparam int unsigned POS_OUTPUT_DIV = 6;
  localparam int unsigned POS_FAST_CLOCK_CFG = 4;
  localparam int unsigned POS_CLOCK_RELOAD_LO = 0;
  localparam int unsigned POS_KEY_LO = 3;
  localparam int unsigned POS_LOCK_STATE = 2;
  localparam int unsigned POS_LOCK_MODE_LO = 0;

  // ****************************************************************
  // Key codes, modes and counts
  // ****************************************************************
  localparam logic [4:0] KEY_OPEN = 5'h13;
  localparam logic [4:0] KEY_CLOSE = 5'h15;
  localparam logic [4:0] KEY_SET_MODE = 5'h18;
  localparam logic [1:0] MODE_PROTECTED = 2'h3;
  localparam int unsigned WINDOW_CYCLES = 32;

endpackage

// ===== verilog/access_window.sv
// Self-closing write access window for the protected bits.
// Assumes one-cycle open and close strobes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module access_window #(
  parameter int unsigned CYCLES = bit_lock_pkg::WINDOW_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic open_pulse,
  input wire logic close_pulse,
  output logic open_q,
  output logic [6:0] remaining_q
);

  // A window must last at least one cycle and fit the counter.
  generate
    if (CYCLES < 1 || CYCLES > 127) begin : g_bad_cycles
      $error("access_window: CYCLES must lie in 1..127");
    end
  endgenerate

  localparam logic [6:0] LOAD = 7'(CYCLES);

  // Opening loads the full count, even while already open; the close key
  // loses only to the open key, though both keys cannot arrive in one write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= 1'b0;
      remaining_q <= 7'h00;
    end else if (ce) begin
      if (open_pulse) begin
        open_q <= 1'b1; // R06 R07
        remaining_q <= LOAD; // R07
      end else if (close_pulse) begin
        open_q <= 1'b0; // R03
        remaining_q <= 7'h00;
      end else if (open_q) begin
        if (remaining_q == 7'h01) begin
          open_q <= 1'b0; // R06
        end
        remaining_q <= remaining_q - 7'h01;
      end
    end
  end

endmodule

`default_nettype wire

// ===== verilog/bit_lock.sv
// Bit write protection lock with the system control registers it guards.
// Assumes an APB master on pclk and same-clock event strobes; the PLL lock
// level comes from another clock domain and is synchronised here.
`timescale 1ns/1ps
`default_nettype none

module bit_lock #(
  parameter int unsigned WINDOW_CYCLES = bit_lock_pkg::WINDOW_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_locked_async,
  input wire logic watchdog_reset_event,
  input wire logic wakeup_event,
  input wire logic powerdown_exit,
  output logic [3:0] feedback_divider,
  output logic output_divider,
  output logic watchdog_enable_bit,
  output logic powerdown_enable,
  output logic slowdown_enable,
  output logic [1:0] wakeup_source,
  output logic wakeup_select,
  output logic vco_bypass,
  output logic osc_disconnect,
  output logic restart_lock_pulse,
  output logic vco_select,
  output logic fast_clock_cfg,
  output logic [3:0] clock_reload,
  output logic lock_state
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  generate
    if (WINDOW_CYCLES < 1 || WINDOW_CYCLES > 127) begin : g_bad_window
      $error("bit_lock: WINDOW_CYCLES must lie in 1..127");
    end
  endgenerate

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic wr_access;
  logic rd_setup;
  logic hit_pmc;
  logic hit_pll;
  logic hit_wdt;
  logic hit_clk;
  logic hit_key;
  logic mapped;
  logic byte_wr;
  logic [7:0] wbyte;

  // Address match for each register; anything else is unmapped.
  assign hit_pmc = (paddr == bit_lock_pkg::ADDR_POWER_MODE_CONTROL_0);
  assign hit_pll = (paddr == bit_lock_pkg::ADDR_CLOCK_MULTIPLIER_CONTROL);
  assign hit_wdt = (paddr == bit_lock_pkg::ADDR_WATCHDOG_CONTROL);
  assign hit_clk = (paddr == bit_lock_pkg::ADDR_CLOCK_CONTROL);
  assign hit_key = (paddr == bit_lock_pkg::ADDR_BIT_LOCK_KEY);
  assign mapped = hit_pmc | hit_pll | hit_wdt | hit_clk | hit_key;

  // The slave never waits; unmapped accesses end with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Writes land at the access edge, and only through the low byte lane.
  assign wr_access = psel & penable & pwrite & mapped & ce;
  assign byte_wr = wr_access & pstrb[0];
  assign wbyte = pwdata[7:0];
  assign rd_setup = psel & ~penable & ~pwrite;

  // ****************************************************************
  // Key register and lock state
  // ****************************************************************
  logic [1:0] lock_mode_q;
  logic [4:0] key_in;
  logic key_wr;
  logic open_pulse;
  logic close_pulse;
  logic window_open;
  logic protect_on;
  logic writes_allowed;

  assign key_wr = byte_wr & hit_key;
  assign key_in = wbyte[bit_lock_pkg::POS_KEY_LO +: 5];

  // Keys only steer the window while the scheme is in protected mode.
  assign protect_on = (lock_mode_q == bit_lock_pkg::MODE_PROTECTED);
  assign open_pulse = key_wr & protect_on & (key_in == bit_lock_pkg::KEY_OPEN); // R02
  assign close_pulse = key_wr & protect_on & (key_in == bit_lock_pkg::KEY_CLOSE); // R03

  // The mode field changes only with the mode key, so open and close
  // writes never disturb it whatever their low bits hold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_mode_q <= bit_lock_pkg::RST_LOCK_MODE; // R09
    end else if (key_wr && (key_in == bit_lock_pkg::KEY_SET_MODE)) begin
      lock_mode_q <= wbyte[bit_lock_pkg::POS_LOCK_MODE_LO +: 2]; // R04 R05
    end
  end

  // Timed window that opens with the open key and closes on its own.
  access_window #(
    .CYCLES(WINDOW_CYCLES)
  ) u_window (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .open_pulse(open_pulse),
    .close_pulse(close_pulse),
    .open_q(window_open),
    .remaining_q()
  );

  // Software writes reach protected bits only with protection off or the window open.
  assign writes_allowed = ~protect_on | window_open; // R01
  assign lock_state = protect_on & ~window_open; // R11

  // ****************************************************************
  // Power mode control register
  // ****************************************************************
  logic pmc_wr;
  logic wdt_flag_q;
  logic wake_flag_q;

  assign pmc_wr = byte_wr & hit_pmc;

  // Unprotected fields of this register update on any write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_source <= bit_lock_pkg::RST_POWER_MODE_CONTROL_0[1:0];
      wakeup_select <= bit_lock_pkg::RST_POWER_MODE_CONTROL_0[bit_lock_pkg::POS_WAKEUP_SELECT];
    end else if (pmc_wr) begin
      wakeup_source <= wbyte[bit_lock_pkg::POS_WAKEUP_SOURCE_LO +: 2]; // R10
      wakeup_select <= wbyte[bit_lock_pkg::POS_WAKEUP_SELECT]; // R10
    end
  end

  // Slow-down enable is a guarded software bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slowdown_enable <= bit_lock_pkg::RST_POWER_MODE_CONTROL_0[bit_lock_pkg::POS_SLOWDOWN];
    end else if (pmc_wr && writes_allowed) begin
      slowdown_enable <= wbyte[bit_lock_pkg::POS_SLOWDOWN]; // R08 R10
    end
  end

  // Power-down enable is guarded; leaving power-down clears it in hardware,
  // and that clear is not subject to the lock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_enable <= bit_lock_pkg::RST_POWER_MODE_CONTROL_0[bit_lock_pkg::POS_POWERDOWN];
    end else if (ce && powerdown_exit) begin
      powerdown_enable <= 1'b0;
    end else if (pmc_wr && writes_allowed) begin
      powerdown_enable <= wbyte[bit_lock_pkg::POS_POWERDOWN]; // R08 R10
    end
  end

  // Sticky event flags: software may write them, but an event in the same
  // cycle as a clearing write still sets the flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_flag_q <= bit_lock_pkg::RST_POWER_MODE_CONTROL_0[bit_lock_pkg::POS_WDT_RESET_FLAG];
      wake_flag_q <= bit_lock_pkg::RST_POWER_MODE_CONTROL_0[bit_lock_pkg::POS_WAKEUP_FLAG];
    end else if (ce) begin
      if (watchdog_reset_event) begin
        wdt_flag_q <= 1'b1;
      end else if (pmc_wr) begin
        wdt_flag_q <= wbyte[bit_lock_pkg::POS_WDT_RESET_FLAG];
      end
      if (wakeup_event) begin
        wake_flag_q <= 1'b1;
      end else if (pmc_wr) begin
        wake_flag_q <= wbyte[bit_lock_pkg::POS_WAKEUP_FLAG];
      end
    end
  end

  // ****************************************************************
  // Clock multiplier control register
  // ****************************************************************
  logic pll_wr;
  logic pll_locked;

  assign pll_wr = byte_wr & hit_pll;

  // Feedback divider is guarded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feedback_divider <=
        bit_lock_pkg::RST_CLOCK_MULTIPLIER_CONTROL[bit_lock_pkg::POS_FEEDBACK_DIV_LO +: 4];
    end else if (pll_wr && writes_allowed) begin
      feedback_divider <= wbyte[bit_lock_pkg::POS_FEEDBACK_DIV_LO +: 4]; // R08 R10
    end
  end

  // Bypass and disconnect update freely.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_bypass <= bit_lock_pkg::RST_CLOCK_MULTIPLIER_CONTROL[bit_lock_pkg::POS_VCO_BYPASS];
      osc_disconnect <=
        bit_lock_pkg::RST_CLOCK_MULTIPLIER_CONTROL[bit_lock_pkg::POS_OSC_DISCONNECT];
    end else if (pll_wr) begin
      vco_bypass <= wbyte[bit_lock_pkg::POS_VCO_BYPASS]; // R10
      osc_disconnect <= wbyte[bit_lock_pkg::POS_OSC_DISCONNECT]; // R10
    end
  end

  // Writing a one to the restart bit gives a one-cycle pulse; it reads 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_lock_pulse <= 1'b0;
    end else if (ce) begin
      restart_lock_pulse <= pll_wr & wbyte[bit_lock_pkg::POS_RESTART_LOCK];
    end
  end

  // The lock level comes from the clock multiplier's own domain.
  pin_sync #(
    .RESET_LEVEL(bit_lock_pkg::RST_CLOCK_MULTIPLIER_CONTROL[bit_lock_pkg::POS_PLL_LOCKED])
  ) u_lock_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in(pll_locked_async),
    .sync_out(pll_locked)
  );

  // ****************************************************************
  // Watchdog control register
  // ****************************************************************
  // Watchdog enable is guarded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_enable_bit <= bit_lock_pkg::RST_WATCHDOG_CONTROL[bit_lock_pkg::POS_WATCHDOG_ENABLE];
    end else if (byte_wr && hit_wdt && writes_allowed) begin
      watchdog_enable_bit <= wbyte[bit_lock_pkg::POS_WATCHDOG_ENABLE]; // R08 R01
    end
  end

  // ****************************************************************
  // Clock control register
  // ****************************************************************
  logic clk_wr;

  assign clk_wr = byte_wr & hit_clk;

  // Output divider is guarded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_divider <= bit_lock_pkg::RST_CLOCK_CONTROL[bit_lock_pkg::POS_OUTPUT_DIV];
    end else if (clk_wr && writes_allowed) begin
      output_divider <= wbyte[bit_lock_pkg::POS_OUTPUT_DIV]; // R08 R10
    end
  end

  // Remaining clock control fields update freely.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_select <= bit_lock_pkg::RST_CLOCK_CONTROL[bit_lock_pkg::POS_VCO_SELECT];
      fast_clock_cfg <= bit_lock_pkg::RST_CLOCK_CONTROL[bit_lock_pkg::POS_FAST_CLOCK_CFG];
      clock_reload <= bit_lock_pkg::RST_CLOCK_CONTROL[bit_lock_pkg::POS_CLOCK_RELOAD_LO +: 4];
    end else if (clk_wr) begin
      vco_select <= wbyte[bit_lock_pkg::POS_VCO_SELECT]; // R10
      fast_clock_cfg <= wbyte[bit_lock_pkg::POS_FAST_CLOCK_CFG]; // R10
      clock_reload <= wbyte[bit_lock_pkg::POS_CLOCK_RELOAD_LO +: 4]; // R10
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] rd_byte;

  // Read view of each register; the key field is write-only and reads 0.
  always_comb begin
    rd_byte = 8'h00;
    unique case (1'b1)
      hit_pmc: begin
        rd_byte = {1'b0, wdt_flag_q, wake_flag_q, wakeup_select, slowdown_enable,
                   powerdown_enable, wakeup_source};
      end
      hit_pll: begin
        rd_byte = {feedback_divider, vco_bypass, osc_disconnect, 1'b0, pll_locked};
      end
      hit_wdt: begin
        rd_byte = {7'h00, watchdog_enable_bit};
      end
      hit_clk: begin
        rd_byte = {vco_select, output_divider, 1'b0, fast_clock_cfg, clock_reload};
      end
      hit_key: begin
        rd_byte = {5'h00, lock_state, lock_mode_q}; // R11
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Read data is captured in the setup cycle and held for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && rd_setup) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

endmodule

`default_nettype wire

// ===== verilog/pin_sync.sv
// Three-stage synchroniser for a level that arrives from outside pclk.
// Assumes a free-running pclk; the output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  // Shift chain; only the second stage reads the first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_q <= RESET_LEVEL;
      stage2_q <= RESET_LEVEL;
      stage3_q <= RESET_LEVEL;
    end else if (ce) begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // Output takes a new level only when the last two stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= RESET_LEVEL;
    end else if (ce && (stage2_q == stage3_q)) begin
      sync_out <= stage3_q;
    end
  end

endmodule

`default_nettype wire
